/* verilog/control_channel_i2c_gpio_cfg.sv */
// Control-channel I2C configuration, bit engine, channel watchdog and GPIO source selection
`timescale 1ns/1ps
`include "ccg_regs.svh"
module control_channel_i2c_gpio_cfg import ccg_pkg::*; #(
  parameter int CHAN_STEP_CYC = `CHAN_STEP_MS * 1000000 / `CLK_NS,
  parameter int GUARD_SLOW_CYC = `GUARD_SLOW_MS * 1000000 / `CLK_NS
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  // Register access
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_REMOTE,
  output logic [7:0] REG_RDATA,
  output logic REG_WR_REFUSED,
  // Control channel
  input wire logic CHAN_BUSY,
  output logic CHAN_ABORT,
  // Bit engine
  input wire logic BIT_START,
  input wire logic BIT_TARGET,
  input wire logic BIT_ACK,
  input wire logic BIT_VAL,
  output logic BIT_DONE,
  output logic BIT_RDATA,
  // I2C pins
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic BUS_FREE,
  // GPIO
  input wire logic [3:0] REMOTE_GPIO,
  output logic [3:0] GPIO_OUT,
  output logic [3:0] GPIO_OE
);
  function automatic count_type cyc_of(input int unsigned t, input int unsigned per);
    int unsigned c;
    c = (t + per - 1) / per;
    if (c == 0) c = 1;
    return count_type'(c);
  endfunction

  logic [7:0] chan_wd_reg, chan_wd_next, i2c_one_reg, i2c_one_next, i2c_two_reg, i2c_two_next;
  logic [7:0] high_reg, high_next, low_reg, low_next, pin_data_reg, pin_data_next;
  logic [7:0] pin_ctrl_reg, pin_ctrl_next, rdata_reg, rdata_next;
  logic refused_reg, refused_next;
  logic [1:0] filt;
  logic [13:0] hold_reg, hold_next;
  logic sda_seen;
  count_type dly_cyc, lo_cyc, hi_cyc, ack_cyc, set_cyc;
  logic [16:0] pre_reg, pre_next;
  logic [6:0] step_reg, step_next;
  logic expired_reg, expired_next, abort_reg, abort_next;
  eng_state_type eng_reg, eng_next;
  count_type cnt_reg, cnt_next, len_reg, len_next;
  logic tgt_reg, tgt_next, ack_reg, ack_next, val_reg, val_next;
  logic scl_oe_reg, scl_oe_next, sda_oe_reg, sda_oe_next;
  logic done_reg, done_next, rbit_reg, rbit_next, scl_pin_reg, zero_reg;
  logic [3:0] gpio_out_reg, gpio_out_next, gpio_oe_reg, gpio_oe_next;
  guard_if gi();

  // Register file
  always_comb begin
    chan_wd_next = chan_wd_reg;
    i2c_one_next = i2c_one_reg;
    i2c_two_next = i2c_two_reg;
    high_next = high_reg;
    low_next = low_reg;
    pin_data_next = pin_data_reg;
    pin_ctrl_next = pin_ctrl_reg;
    refused_next = 1'b0;
    if (REG_WR) begin
      if (REG_REMOTE && i2c_one_reg[`F_BLOCK]) begin
        refused_next = 1'b1;
      end else begin
        case (REG_ADDR)
          `A_CHAN_WD: chan_wd_next = REG_WDATA;
          `A_I2C_ONE: i2c_one_next = REG_WDATA;
          `A_I2C_TWO: i2c_two_next = REG_WDATA;
          `A_HIGH: high_next = REG_WDATA;
          `A_LOW: low_next = REG_WDATA;
          `A_PIN_DATA: pin_data_next = REG_WDATA;
          `A_PIN_CTRL: pin_ctrl_next = REG_WDATA;
          default: ;
        endcase
      end
    end
    case (REG_ADDR)
      `A_CHAN_WD: rdata_next = chan_wd_reg;
      `A_I2C_ONE: rdata_next = i2c_one_reg;
      `A_I2C_TWO: rdata_next = i2c_two_reg;
      `A_HIGH: rdata_next = high_reg;
      `A_LOW: rdata_next = low_reg;
      `A_PIN_DATA: rdata_next = pin_data_reg;
      `A_PIN_CTRL: rdata_next = pin_ctrl_reg;
      `A_STATUS: rdata_next = {4'h0, expired_reg, eng_reg != ST_IDLE, gi.recov, gi.free};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      chan_wd_reg <= `R_CHAN_WD;
      i2c_one_reg <= `R_I2C_ONE;
      i2c_two_reg <= `R_I2C_TWO;
      high_reg <= `R_HIGH;
      low_reg <= `R_LOW;
      pin_data_reg <= `R_PIN_DATA;
      pin_ctrl_reg <= `R_PIN_CTRL;
      rdata_reg <= 8'h00;
      refused_reg <= 1'b0;
    end else if (CE) begin
      chan_wd_reg <= chan_wd_next;
      i2c_one_reg <= i2c_one_next;
      i2c_two_reg <= i2c_two_next;
      high_reg <= high_next;
      low_reg <= low_next;
      pin_data_reg <= pin_data_next;
      pin_ctrl_reg <= pin_ctrl_next;
      rdata_reg <= rdata_next;
      refused_reg <= refused_next;
    end
  end

  // Line conditioning
  genvar g;
  for (g = 0; g < 2; g++) begin : g_filt
    glitch_filter u_filt (
      .clk(CLK),
      .nrst(NRST),
      .ce(CE),
      .depth(i2c_one_reg[3:0]),
      .din(g == 0 ? SCL_IN : SDA_IN),
      .dout(filt[g])
    );
  end

  always_comb begin
    hold_next = {hold_reg[12:0], filt[1]};
    // Hold delays SDA so a late SDA change is not seen as a start or stop
    if (i2c_one_reg[`F_HOLD +: 3] == 3'h0) begin
      sda_seen = filt[1];
    end else begin
      sda_seen = hold_reg[int'(i2c_one_reg[`F_HOLD +: 3]) * `HOLD_NS / `CLK_NS - 1];
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      hold_reg <= 14'h3FFF;
    end else if (CE) begin
      hold_reg <= hold_next;
    end
  end

  always_comb begin
    dly_cyc = cyc_of(`DLY_BASE_NS + `DLY_UNIT_NS * int'(i2c_two_reg[`F_DELAY +: 2]), `CLK_NS);
    ack_cyc = cyc_of(`ACK_BASE_NS + `ACK_UNIT_NS * int'(i2c_two_reg[`F_SETUP +: 4]), `CLK_NS);
    lo_cyc = cyc_of(`OSC_UNIT_100FS * (int'(low_reg) + `OSC_EXTRA), `CLK_100FS);
    hi_cyc = cyc_of(`OSC_UNIT_100FS * (int'(high_reg) + `OSC_EXTRA), `CLK_100FS);
    set_cyc = (lo_cyc > dly_cyc) ? lo_cyc - dly_cyc : 12'h001;
  end

  // Control-channel watchdog
  always_comb begin
    pre_next = pre_reg + 17'h00001;
    step_next = step_reg;
    expired_next = expired_reg;
    abort_next = 1'b0;
    if (!CHAN_BUSY || chan_wd_reg[`F_WD_OFF]) begin
      pre_next = 17'h00000;
      step_next = 7'h00;
      expired_next = 1'b0;
    end else if (expired_reg) begin
      pre_next = pre_reg;
    end else if (pre_reg == 17'(CHAN_STEP_CYC - 1)) begin
      pre_next = 17'h00000;
      step_next = step_reg + 7'h01;
      if (step_reg + 7'h01 >= chan_wd_reg[7:1]) begin
        abort_next = 1'b1;
        expired_next = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pre_reg <= 17'h00000;
      step_reg <= 7'h00;
      expired_reg <= 1'b0;
      abort_reg <= 1'b0;
    end else if (CE) begin
      pre_reg <= pre_next;
      step_reg <= step_next;
      expired_reg <= expired_next;
      abort_reg <= abort_next;
    end
  end

  // Bit engine: one SCL period as controller, or one stretched bit as target
  always_comb begin
    eng_next = eng_reg;
    cnt_next = cnt_reg - 12'h001;
    tgt_next = tgt_reg;
    ack_next = ack_reg;
    val_next = val_reg;
    scl_oe_next = scl_oe_reg;
    sda_oe_next = sda_oe_reg;
    done_next = 1'b0;
    rbit_next = rbit_reg;
    unique case (eng_reg)
      ST_IDLE: begin
        cnt_next = cnt_reg;
        if (BIT_START && !gi.recov) begin
          eng_next = ST_DELAY;
          tgt_next = BIT_TARGET;
          ack_next = BIT_ACK;
          val_next = BIT_VAL;
          cnt_next = dly_cyc - 12'h001;
          scl_oe_next = 1'b1;
        end
      end
      ST_DELAY: begin
        if (cnt_reg == 12'h000) begin
          eng_next = ST_SETUP;
          sda_oe_next = !val_reg;
          if (!tgt_reg) begin
            cnt_next = set_cyc - 12'h001;
          end else if (ack_reg) begin
            cnt_next = ack_cyc - 12'h001;
          end else begin
            cnt_next = lo_cyc - 12'h001;
          end
        end
      end
      ST_SETUP: begin
        if (cnt_reg == 12'h000) begin
          eng_next = ST_HIGH;
          scl_oe_next = 1'b0;
          cnt_next = hi_cyc - 12'h001;
        end
      end
      ST_HIGH: begin
        // A slave stretching SCL holds the high count back
        if (!filt[0]) begin
          cnt_next = cnt_reg;
        end else if (tgt_reg || cnt_reg == 12'h000) begin
          eng_next = ST_IDLE;
          done_next = 1'b1;
          rbit_next = sda_seen;
        end
      end
    endcase
    if (abort_next) begin
      eng_next = ST_IDLE;
      scl_oe_next = 1'b0;
      sda_oe_next = 1'b0;
    end
    len_next = (eng_next != eng_reg) ? 12'h000 : len_reg + 12'h001;
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      eng_reg <= ST_IDLE;
      cnt_reg <= 12'h000;
      len_reg <= 12'h000;
      tgt_reg <= 1'b0;
      ack_reg <= 1'b0;
      val_reg <= 1'b1;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      done_reg <= 1'b0;
      rbit_reg <= 1'b0;
    end else if (CE) begin
      eng_reg <= eng_next;
      cnt_reg <= cnt_next;
      len_reg <= len_next;
      tgt_reg <= tgt_next;
      ack_reg <= ack_next;
      val_reg <= val_next;
      scl_oe_reg <= scl_oe_next;
      sda_oe_reg <= sda_oe_next;
      done_reg <= done_next;
      rbit_reg <= rbit_next;
    end
  end

  // Bus watchdog
  assign gi.ce = CE;
  assign gi.scl = filt[0];
  assign gi.sda = sda_seen;
  assign gi.off = i2c_two_reg[`F_GUARD_OFF];
  assign gi.fast = i2c_two_reg[`F_FAST];
  bus_guard #(.SLOW_CYC(GUARD_SLOW_CYC)) u_guard (
    .clk(CLK),
    .nrst(NRST),
    .gi(gi.guard)
  );

  // GPIO source and pin registers
  always_comb begin
    gpio_out_next = (pin_data_reg[7:4] & REMOTE_GPIO)
      | (~pin_data_reg[7:4] & pin_data_reg[3:0]);
    gpio_oe_next = pin_data_reg[7:4] | pin_ctrl_reg[7:4];
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      gpio_out_reg <= 4'h0;
      gpio_oe_reg <= 4'h0;
      scl_pin_reg <= 1'b0;
      zero_reg <= 1'b0;
    end else if (CE) begin
      gpio_out_reg <= gpio_out_next;
      gpio_oe_reg <= gpio_oe_next;
      scl_pin_reg <= scl_oe_reg | gi.scl_drv;
      zero_reg <= 1'b0;
    end
  end

  assign REG_RDATA = rdata_reg;
  assign REG_WR_REFUSED = refused_reg;
  assign CHAN_ABORT = abort_reg;
  assign BIT_DONE = done_reg;
  assign BIT_RDATA = rbit_reg;
  assign SCL_OUT = zero_reg;
  assign SDA_OUT = zero_reg;
  assign SCL_OE = scl_pin_reg;
  assign SDA_OE = sda_oe_reg;
  assign BUS_FREE = gi.free;
  assign GPIO_OUT = gpio_out_reg;
  assign GPIO_OE = gpio_oe_reg;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  property p_block;
    (CE && REG_WR && REG_REMOTE && i2c_one_reg[`F_BLOCK])
      |=> (REG_WR_REFUSED && $stable(chan_wd_reg) && $stable(i2c_one_reg)
        && $stable(pin_data_reg));
  endproperty
  a_block: assert property (p_block) else $error("remote write not refused");
  property p_wd_off;
    ($past(CE) && $past(chan_wd_reg[`F_WD_OFF])) |-> !CHAN_ABORT;
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("abort while watchdog off");
  property p_abort_busy;
    CHAN_ABORT |-> $past(CHAN_BUSY);
  endproperty
  a_abort_busy: assert property (p_abort_busy) else $error("abort without transaction");
  property p_release;
    (CE && abort_next) |=> (CHAN_ABORT && eng_reg == ST_IDLE && !SDA_OE) ##1 !SCL_OE || gi.scl_drv;
  endproperty
  a_release: assert property (p_release) else $error("bus not released on abort");
  property p_delay;
    (CE && eng_reg == ST_DELAY && eng_next == ST_SETUP) |-> len_reg + 12'h001 == dly_cyc;
  endproperty
  a_delay: assert property (p_delay) else $error("SDA output delay wrong");
  property p_low;
    (CE && eng_reg == ST_SETUP && eng_next == ST_HIGH && !tgt_reg)
      |-> len_reg + 12'h001 + dly_cyc >= lo_cyc;
  endproperty
  a_low: assert property (p_low) else $error("SCL low time short");
  property p_tgt;
    (CE && eng_reg == ST_SETUP && eng_next == ST_HIGH && tgt_reg)
      |-> len_reg + 12'h001 == (ack_reg ? ack_cyc : lo_cyc);
  endproperty
  a_tgt: assert property (p_tgt) else $error("target data setup wrong");
  property p_high;
    (CE && eng_reg == ST_HIGH && eng_next == ST_IDLE && !tgt_reg && !abort_next)
      |-> len_reg + 12'h001 >= hi_cyc;
  endproperty
  a_high: assert property (p_high) else $error("SCL high time short");
  property p_remote;
    (CE && pin_data_reg[7:4] == 4'hF) |=> (GPIO_OUT == $past(REMOTE_GPIO) && GPIO_OE == 4'hF);
  endproperty
  a_remote: assert property (p_remote) else $error("remote GPIO not forwarded");
  property p_local;
    (CE && pin_data_reg[7:4] == 4'h0) |=> GPIO_OE == $past(pin_ctrl_reg[7:4]);
  endproperty
  a_local: assert property (p_local) else $error("local GPIO enable wrong");
  c_abort: cover property (CE && abort_next && eng_reg != ST_IDLE);
  c_refused: cover property (REG_WR_REFUSED);
  c_ack: cover property (BIT_DONE && ack_reg && tgt_reg);
endmodule

/* verilog/ccg_regs.svh */
// Register offsets, field positions, reset values and timing figures of the I2C/GPIO block
`ifndef CCG_REGS_SVH
`define CCG_REGS_SVH
`define A_CHAN_WD 8'h08
`define A_I2C_ONE 8'h09
`define A_I2C_TWO 8'h0A
`define A_HIGH 8'h0B
`define A_LOW 8'h0C
`define A_PIN_DATA 8'h0D
`define A_PIN_CTRL 8'h0E
`define A_STATUS 8'h0F
`define R_CHAN_WD 8'hFE
`define R_I2C_ONE 8'h1E
`define R_I2C_TWO 8'h10
`define R_HIGH 8'h7F
`define R_LOW 8'h7F
`define R_PIN_DATA 8'hF0
`define R_PIN_CTRL 8'h0F
`define F_WD_OFF 0
`define F_BLOCK 7
`define F_HOLD 4
`define F_SETUP 4
`define F_DELAY 2
`define F_FAST 1
`define F_GUARD_OFF 0
`define CLK_NS 25
`define CLK_100FS 250000
`define CHAN_STEP_MS 2
`define HOLD_NS 50
`define FILT_NS 5
`define ACK_BASE_NS 80
`define ACK_UNIT_NS 640
`define DLY_BASE_NS 240
`define DLY_UNIT_NS 40
`define OSC_UNIT_100FS 380952
`define OSC_EXTRA 5
`define GUARD_SLOW_MS 1000
`define GUARD_FAST_US 50
`define RECOV_PULSES 9
`define RECOV_HALF_NS 5000
`endif

/* verilog/ccg_pkg.sv */
// Types shared by the I2C/GPIO block modules
package ccg_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_DELAY = 4'h2, ST_SETUP = 4'h4, ST_HIGH = 4'h8
  } eng_state_type;
  typedef enum logic [2:0] {G_WATCH = 3'h1, G_LOW = 3'h2, G_HIGH = 3'h4} guard_state_type;
  typedef logic [11:0] count_type;
endpackage

/* verilog/guard_if.sv */
// Signals between the core and the bus watchdog
`timescale 1ns/1ps
interface guard_if;
  logic ce;
  logic scl;
  logic sda;
  logic off;
  logic fast;
  logic free;
  logic recov;
  logic scl_drv;
  modport guard(input ce, scl, sda, off, fast, output free, recov, scl_drv);
  modport core(output ce, scl, sda, off, fast, input free, recov, scl_drv);
endinterface

/* verilog/glitch_filter.sv */
// Pin synchroniser and glitch filter for one I2C line
`timescale 1ns/1ps
`include "ccg_regs.svh"
module glitch_filter import ccg_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Line
  input wire logic [3:0] depth,
  input wire logic din,
  output logic dout
);
  logic s1_reg, s2_reg, s3_reg, out_reg;
  logic [2:0] cnt_reg, cnt_next;
  logic out_next;
  logic [2:0] lim;

  always_comb begin
    lim = 3'((int'(depth) * `FILT_NS + `CLK_NS - 1) / `CLK_NS);
    out_next = out_reg;
    cnt_next = 3'h0;
    // A new level must outlast the glitch window before it is taken
    if (s2_reg == s3_reg && s3_reg != out_reg) begin
      if (cnt_reg >= lim) begin
        out_next = s3_reg;
      end else begin
        cnt_next = cnt_reg + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      out_reg <= 1'b1;
      cnt_reg <= 3'h0;
    end else if (ce) begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
      cnt_reg <= cnt_next;
    end
  end
  assign dout = out_reg;
endmodule

/* verilog/bus_guard.sv */
// Local I2C bus watchdog: free-bus detection and nine-clock recovery
`timescale 1ns/1ps
`include "ccg_regs.svh"
module bus_guard import ccg_pkg::*; #(
  parameter int SLOW_CYC = `GUARD_SLOW_MS * 1000000 / `CLK_NS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Core side
  guard_if.guard gi
);
  localparam int FAST_CYC = `GUARD_FAST_US * 1000 / `CLK_NS;
  localparam int HALF_CYC = `RECOV_HALF_NS / `CLK_NS;
  guard_state_type st_reg, st_next;
  logic [25:0] cnt_reg, cnt_next, lim;
  logic [3:0] n_reg, n_next;
  logic [1:0] prev_reg, prev_next;
  logic free_reg, free_next, drv_reg, drv_next, recov_reg, recov_next;

  always_comb begin
    lim = gi.fast ? 26'(FAST_CYC) : 26'(SLOW_CYC);
    st_next = st_reg;
    cnt_next = cnt_reg + 26'h0000001;
    n_next = n_reg;
    free_next = free_reg;
    drv_next = drv_reg;
    prev_next = {gi.sda, gi.scl};
    unique case (st_reg)
      G_WATCH: begin
        if (prev_reg != {gi.sda, gi.scl}) begin
          cnt_next = 26'h0000000;
          free_next = 1'b0;
        end else if (cnt_reg >= lim - 26'h0000001) begin
          cnt_next = 26'h0000000;
          if (gi.sda) begin
            free_next = 1'b1;
          end else begin
            st_next = G_LOW;
            drv_next = 1'b1;
            n_next = 4'h0;
          end
        end
      end
      G_LOW: begin
        if (cnt_reg == 26'(HALF_CYC - 1)) begin
          cnt_next = 26'h0000000;
          drv_next = 1'b0;
          st_next = G_HIGH;
        end
      end
      G_HIGH: begin
        if (cnt_reg == 26'(HALF_CYC - 1)) begin
          cnt_next = 26'h0000000;
          n_next = n_reg + 4'h1;
          if (n_reg == 4'(`RECOV_PULSES - 1)) begin
            st_next = G_WATCH;
          end else begin
            st_next = G_LOW;
            drv_next = 1'b1;
          end
        end
      end
    endcase
    if (gi.off) begin
      st_next = G_WATCH;
      cnt_next = 26'h0000000;
      free_next = 1'b0;
      drv_next = 1'b0;
    end
    recov_next = st_next != G_WATCH;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= G_WATCH;
      cnt_reg <= 26'h0000000;
      n_reg <= 4'h0;
      prev_reg <= 2'h3;
      free_reg <= 1'b0;
      drv_reg <= 1'b0;
      recov_reg <= 1'b0;
    end else if (gi.ce) begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      n_reg <= n_next;
      prev_reg <= prev_next;
      free_reg <= free_next;
      drv_reg <= drv_next;
      recov_reg <= recov_next;
    end
  end
  assign gi.free = free_reg;
  assign gi.recov = recov_reg;
  assign gi.scl_drv = drv_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_guard_off;
    (gi.ce && gi.off) |=> (!gi.recov && !gi.scl_drv && !gi.free);
  endproperty
  a_guard_off: assert property (p_guard_off) else $error("bus watchdog ran while off");
  property p_nine;
    (gi.ce && st_reg == G_HIGH && st_next == G_WATCH && !gi.off) |-> n_reg == 4'h8;
  endproperty
  a_nine: assert property (p_nine) else $error("recovery pulse count not nine");
  property p_free;
    $rose(free_reg) |-> $past(gi.sda) && $past(prev_reg[1]);
  endproperty
  a_free: assert property (p_free) else $error("bus freed with SDA low");
  c_recov: cover property (st_reg == G_HIGH && st_next == G_WATCH);
endmodule

/* verif/i2c_pullup_model.sv */
// Local I2C bus with pull-ups and one target that can hang SDA low
`timescale 1ns/1ps
module i2c_pullup_model (
  // Device open-drain enables
  input wire logic scl_oe,
  input wire logic sda_oe,
  // Target misbehaviour command
  input wire logic hang,
  // Resolved wires
  output logic scl,
  output logic sda
);
  // Released lines float up to the pull-up level
  assign scl = !scl_oe;
  // A hung target keeps SDA low regardless of clocks
  assign sda = !(sda_oe || hang);
endmodule

/* verif/control_channel_i2c_gpio_cfg_bench.sv */
// Self-checking bench of the I2C/GPIO block
`timescale 1ns/1ps
module control_channel_i2c_gpio_cfg_bench;
  logic CLK = 0, NRST = 0, CE = 1, REG_WR = 0, REG_REMOTE = 0, CHAN_BUSY = 0;
  logic BIT_START = 0, BIT_TARGET = 0, BIT_ACK = 0, BIT_VAL = 1, hang = 0, rd_v = 0;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REG_RDATA;
  logic [3:0] REMOTE_GPIO = 4'h0, GPIO_OUT, GPIO_OE;
  logic REG_WR_REFUSED, CHAN_ABORT, BIT_DONE, BIT_RDATA, BUS_FREE;
  logic SCL_OUT, SCL_OE, SDA_OUT, SDA_OE, scl, sda, oe_d;
  logic [7:0] q[$];
  int err_total = 0, n_checks = 0, n, i;
  logic [7:0] ra[8] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h20};
  logic [7:0] rv[8] = '{8'hFE, 8'h1E, 8'h10, 8'h7F, 8'h7F, 8'hF0, 8'h0F, 8'h00};
  initial forever #12.5 CLK = ~CLK;
  control_channel_i2c_gpio_cfg #(.CHAN_STEP_CYC(20), .GUARD_SLOW_CYC(500))
    u_control_channel_i2c_gpio_cfg (
    .CLK(CLK), .NRST(NRST), .CE(CE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_REMOTE(REG_REMOTE), .REG_RDATA(REG_RDATA),
    .REG_WR_REFUSED(REG_WR_REFUSED), .CHAN_BUSY(CHAN_BUSY), .CHAN_ABORT(CHAN_ABORT),
    .BIT_START(BIT_START), .BIT_TARGET(BIT_TARGET), .BIT_ACK(BIT_ACK), .BIT_VAL(BIT_VAL),
    .BIT_DONE(BIT_DONE), .BIT_RDATA(BIT_RDATA), .SCL_IN(scl), .SDA_IN(sda),
    .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
    .BUS_FREE(BUS_FREE), .REMOTE_GPIO(REMOTE_GPIO), .GPIO_OUT(GPIO_OUT), .GPIO_OE(GPIO_OE));
  i2c_pullup_model u_i2c_pullup_model (.scl_oe(SCL_OE), .sda_oe(SDA_OE), .hang(hang),
    .scl(scl), .sda(sda));
  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic tmo();
    err_total++;
    end_sim();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic r);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1;
    REG_REMOTE <= r;
    @(posedge CLK);
    REG_WR <= 0;
    REG_REMOTE <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge CLK);
    REG_ADDR <= a;
    q.push_back(e);
    @(posedge CLK);
    rd_v <= 1;
    @(posedge CLK);
    rd_v <= 0;
  endtask
  // Drives one bit and returns the cycles SCL was pulled low
  task automatic bit_go(input logic v, input logic t, input logic a, output int cnt);
    @(posedge CLK);
    BIT_START <= 1;
    BIT_TARGET <= t;
    BIT_ACK <= a;
    BIT_VAL <= v;
    q.push_back({7'h00, v});
    @(posedge CLK);
    BIT_START <= 0;
    cnt = 0;
    for (i = 0; i < 3000 && BIT_DONE !== 1'b1; i++) begin
      @(negedge CLK);
      if (SCL_OE === 1'b1) cnt++;
    end
    if (i == 3000) tmo();
  endtask
  // Results are compared against the oldest note as they appear
  always @(negedge CLK) begin
    if (rd_v && q.size() > 0) chk("read", REG_RDATA, q.pop_front());
    if (BIT_DONE === 1'b1 && q.size() > 0) chk("bit", BIT_RDATA, q.pop_front());
  end
  initial begin
    void'($urandom(2));
    repeat (10) @(posedge CLK);
    NRST <= 1;
    for (int k = 0; k < 8; k++) rd(ra[k], rv[k]);
    @(posedge CLK) REMOTE_GPIO <= 4'($urandom);
    repeat (3) @(posedge CLK);
    #1 chk("gpio_remote", GPIO_OUT, REMOTE_GPIO);
    chk("gpio_oe", GPIO_OE, 4'hF);
    wr(8'h0E, 8'hF0, 0);
    wr(8'h0D, 8'h05, 0);
    @(posedge CLK);
    #1 chk("gpio_local", GPIO_OUT, 4'h5);
    wr(8'h09, 8'h9E, 0);
    wr(8'h0B, 8'h11, 1);
    #1 chk("refused", REG_WR_REFUSED, 1'b1);
    rd(8'h0B, 8'h7F);
    wr(8'h09, 8'h1E, 1);
    wr(8'h09, 8'h1E, 0);
    // Nonzero timeout of two steps
    wr(8'h08, 8'h04, 0);
    @(posedge CLK) CHAN_BUSY <= 1;
    for (n = 1; n < 200; n++) begin
      @(posedge CLK);
      #1 if (CHAN_ABORT === 1'b1) break;
    end
    chk("abort_cycles", 12'(n), 12'd40);
    @(posedge CLK) CHAN_BUSY <= 0;
    wr(8'h08, 8'h05, 0);
    @(posedge CLK) CHAN_BUSY <= 1;
    n = 0;
    repeat (100) @(negedge CLK) n += CHAN_ABORT;
    chk("abort_off", 12'(n), 12'd0);
    @(posedge CLK) CHAN_BUSY <= 0;
    wr(8'h0C, 8'h20, 0);
    bit_go(0, 0, 0, n);
    chk("scl_low", 12'(n), 12'd57);
    bit_go(1, 0, 0, n);
    chk("scl_low_one", 12'(n), 12'd57);
    // Target bits hold SCL for the output delay plus ack setup or low time
    bit_go(0, 1, 1, n);
    chk("ack_setup", 12'(n), 12'd39);
    bit_go(1, 1, 0, n);
    chk("target_setup", 12'(n), 12'd67);
    for (n = 0; n < 700 && BUS_FREE !== 1'b1; n++) @(negedge CLK);
    chk("bus_free", BUS_FREE, 1'b1);
    wr(8'h0A, 8'h11, 0);
    @(posedge CLK) hang <= 1;
    n = 0;
    repeat (800) @(negedge CLK) n += (SCL_OE === 1'b1 && oe_d === 1'b0);
    chk("guard_off", 12'(n), 12'd0);
    wr(8'h0A, 8'h12, 0);
    for (n = 0; n < 3000 && SCL_OE !== 1'b1; n++) @(negedge CLK);
    chk("guard_fast", 12'(n >= 2000 && n <= 2010), 12'd1);
    // Window ends before a second recovery can start on the still hung bus
    n = 1;
    repeat (4000) @(negedge CLK) n += (SCL_OE === 1'b1 && oe_d === 1'b0);
    chk("recovery_pulses", 12'(n), 12'd9);
    wr(8'h0A, 8'h11, 0);
    wr(8'h0A, 8'h10, 0);
    for (n = 0; n < 1000 && SCL_OE !== 1'b1; n++) @(negedge CLK);
    chk("guard_slow", 12'(n >= 500 && n <= 510), 12'd1);
    @(posedge CLK) hang <= 0;
    end_sim();
  end
  always @(posedge CLK) oe_d <= SCL_OE;
endmodule
